// *** include/wake_boot_pkg.sv ***
package wake_boot_pkg;

    // clock and timing
    localparam int unsigned CLK_HZ             = 50_000_000;
    localparam int unsigned BOOT_FIXED_US      = 2000;   // fixed boot copy time, 2 ms
    localparam int unsigned BOOT_PER_KB_US     = 3600;   // per kilobyte copy time, 3.6 ms
    localparam int unsigned BOOT_FIXED_CYC     = (CLK_HZ / 1_000_000) * BOOT_FIXED_US;
    localparam int unsigned BOOT_PER_KB_CYC    = (CLK_HZ / 1_000_000) * BOOT_PER_KB_US;
    localparam int unsigned RAM_KB             = 4;      // code/data ram size
    localparam int unsigned RAM_BYTES          = 4096;
    localparam int unsigned RET_BYTES          = 8;      // retention ram size
    localparam int unsigned OSC_NOMINAL_MHZ    = 24;
    localparam int unsigned OSC_START_CYC      = 16;     // oscillator settle wait
    localparam int unsigned XTAL_START_CYC     = 64;     // crystal settle wait
    localparam int unsigned SYNC_STAGES        = 3;
    localparam int unsigned DIV_MAX_LOG2       = 7;      // divider up to 128
    localparam int unsigned NUM_PERIPH         = 8;
    localparam int unsigned NUM_GPIO           = 9;

    // reset values
    localparam logic [2:0]  RST_DIV_SEL        = 3'h0;
    localparam logic [7:0]  RST_PERIPH_OFF     = 8'h00;

    // power sequence, gray along wake path
    typedef enum logic [2:0]
    {
        ST_POR     = 3'b000,
        ST_STANDBY = 3'b001,
        ST_OSC_ON  = 3'b011,
        ST_BOOT    = 3'b010,
        ST_RUN     = 3'b110
    } pwr_state_e;

endpackage : wake_boot_pkg

// *** include/boot_copy_if.sv ***
interface boot_copy_if;
    import wake_boot_pkg::*;

    logic        start;
    logic        busy;
    logic        done;
    logic [11:0] addr;
    logic        wr;

    modport ctrl (output start, input busy, input done, input addr, input wr);
    modport copier (input start, output busy, output done, output addr, output wr);
endinterface : boot_copy_if

// *** hw/boot_copier.sv ***
module boot_copier
    import wake_boot_pkg::*;
#(
    parameter int unsigned FIXED_CYC = BOOT_FIXED_CYC,
    parameter int unsigned KB_CYC    = BOOT_PER_KB_CYC,
    parameter int unsigned KB_COUNT  = RAM_KB
)(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // control side
    boot_copy_if.copier bc
);
    import wake_boot_pkg::*;

    localparam int unsigned TOTAL_CYC = FIXED_CYC + KB_CYC * KB_COUNT;
    localparam int unsigned WORDS     = KB_COUNT * 1024;

    logic [31:0] cnt;
    logic [31:0] wcnt;
    logic        run;

    // copy timer; one ram byte written each cycle from the end of the fixed phase until all WORDS bytes are written
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            run  <= 1'b0;
            cnt  <= 32'h0;
            wcnt <= 32'h0;
        end
        else if (bc.start && !run)
        begin
            run  <= 1'b1;
            cnt  <= 32'h0;
            wcnt <= 32'h0;
        end
        else if (run)
        begin
            cnt <= cnt + 32'h1;
            if (cnt >= FIXED_CYC && wcnt < WORDS)
                wcnt <= wcnt + 32'h1;
            if (cnt == TOTAL_CYC - 1)
                run <= 1'b0;
        end
    end

    assign bc.busy = run;
    assign bc.done = run && (cnt == TOTAL_CYC - 1);
    assign bc.wr   = run && (cnt >= FIXED_CYC) && (wcnt < WORDS);
    assign bc.addr = wcnt[11:0];

    chk_copy_length: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(run) |-> run [*8]) else $error("copy ended too early");

endmodule : boot_copier

// *** hw/wake_boot_sequencer.sv ***
// Contract
// - after power-on reset the device goes straight to standby, not to running code.
// - in standby all blocks are off except an 8-byte retention ram that keeps its data.
// - a falling edge on any general-purpose pin wakes the device from standby.
// - a sleep timer wakes the device periodically with no pin edge.
// - on wake the boot loader copies the image from otp into the 4 kB code ram.
// - the copy repeats on every wake and lasts 2 ms plus 3.6 ms per kilobyte.
// - the processor runs only after the copy finishes, and may then call rom routines.
// - the 24 MHz low-power oscillator clocks the processor and stops only in standby; the code also holds it off in ST_POR.
// - the system clock divider is programmable so the processor can run slower.
// - the real-time clock and timers two and three are timed from the low-power oscillator.
// - an enabled crystal oscillator runs before a transmission to trim the carrier reference, then stops.
// - the power-on reset puts the whole chip into a known state; the code leaves the retention ram contents unreset.
// - software may shut down each peripheral on its own or all together.
module wake_boot_sequencer
    import wake_boot_pkg::*;
#(
    parameter int unsigned GPIO_W     = NUM_GPIO,
    parameter int unsigned PERIPH_W   = NUM_PERIPH,
    parameter int unsigned SLEEP_W    = 32,
    parameter int unsigned FIXED_CYC  = BOOT_FIXED_CYC,
    parameter int unsigned KB_CYC     = BOOT_PER_KB_CYC
)(
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rstn_i,
    // wake sources
    input  wire logic [GPIO_W-1:0]     gpio_i,
    input  wire logic                  sleep_en_i,
    input  wire logic [SLEEP_W-1:0]    sleep_period_i,
    // processor requests
    input  wire logic                  standby_req_i,
    input  wire logic [2:0]            clk_div_sel_i,
    input  wire logic                  clk_div_load_i,
    input  wire logic [PERIPH_W-1:0]   periph_off_i,
    input  wire logic                  periph_all_off_i,
    input  wire logic                  xtal_en_i,
    input  wire logic                  tx_req_i,
    input  wire logic                  carrier_trim_done_i,
    // retention ram port
    input  wire logic                  ret_we_i,
    input  wire logic [2:0]            ret_addr_i,
    input  wire logic [7:0]            ret_wdata_i,
    output logic [7:0]                 ret_rdata_o,
    // boot copy ram port
    output logic                       otp_rd_o,
    output logic                       ram_we_o,
    output logic [11:0]                ram_addr_o,
    // power and clock outputs
    output logic                       low_power_oscillator_en_o,
    output logic                       crystal_oscillator_en_o,
    output logic                       blocks_pwr_en_o,
    output logic                       cpu_run_o,
    output logic                       sys_clk_en_o,
    output logic                       timer_tick_o,
    output logic [PERIPH_W-1:0]        periph_pwr_o,
    output logic                       standby_o,
    output logic                       booting_o
);
    import wake_boot_pkg::*;

    pwr_state_e state;
    pwr_state_e next_state;

    boot_copy_if bc ();

    logic [GPIO_W-1:0]  gs1;
    logic [GPIO_W-1:0]  gs2;
    logic [GPIO_W-1:0]  gs3;
    logic [GPIO_W-1:0]  gprev;
    logic               pin_wake;
    logic [SLEEP_W-1:0] sleep_cnt;
    logic               timer_wake;
    logic [7:0]         osc_cnt;
    logic [7:0]         retention_ram [RET_BYTES];
    logic [2:0]         div_sel;
    logic [6:0]         div_cnt;
    logic [PERIPH_W-1:0] periph_off;
    logic [7:0]         xtal_cnt;
    logic               xtal_on;

    // three-stage pin synchroniser; only stage two and three agreeing counts
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            gs1   <= '1;
            gs2   <= '1;
            gs3   <= '1;
            gprev <= '1;
        end
        else
        begin
            gs1 <= gpio_i;
            gs2 <= gs1;
            gs3 <= gs2;
            if (gs2 == gs3)
                gprev <= gs3;
        end
    end

    // falling edge on any pin; wakes only count in standby
    assign pin_wake = |(gprev & ~gs3 & ~gs2) && (state == ST_STANDBY);

    // sleep timer runs in standby only, counting every clk_i cycle
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i || state != ST_STANDBY || !sleep_en_i)
            sleep_cnt <= '0;
        else if (timer_wake)
            sleep_cnt <= '0;
        else
            sleep_cnt <= sleep_cnt + 1'b1;
    end

    // period of zero would wake at once, so it is treated as off
    assign timer_wake = sleep_en_i && (state == ST_STANDBY) && (sleep_period_i != '0)
                        && (sleep_cnt >= sleep_period_i - 1'b1);

    // power sequence
    always_comb
    begin
        next_state = state;
        case (state)
            ST_POR:     next_state = ST_STANDBY;
            ST_STANDBY: if (pin_wake || timer_wake) next_state = ST_OSC_ON;
            ST_OSC_ON:  if (osc_cnt == OSC_START_CYC[7:0] - 8'h1) next_state = ST_BOOT;
            ST_BOOT:    if (bc.done) next_state = ST_RUN;
            ST_RUN:     if (standby_req_i) next_state = ST_STANDBY;
            default:    next_state = ST_POR;
        endcase
    end

    // state register loads ST_POR on reset
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            state <= ST_POR;
        else
            state <= next_state;
    end

    // oscillator settle counter
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i || state != ST_OSC_ON)
            osc_cnt <= 8'h0;
        else
            osc_cnt <= osc_cnt + 8'h1;
    end

    // kick the copier once on entry to boot, every wake
    assign bc.start = (state == ST_OSC_ON) && (next_state == ST_BOOT);

    boot_copier #(
        .FIXED_CYC (FIXED_CYC),
        .KB_CYC    (KB_CYC),
        .KB_COUNT  (RAM_KB)
    ) u_copier (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .bc     (bc.copier)
    );

    assign otp_rd_o   = bc.wr;
    assign ram_we_o   = bc.wr;
    assign ram_addr_o = bc.addr;

    // retention ram is not reset: contents must survive wake cycles
    always_ff @(posedge clk_i)
    begin
        if (ret_we_i && state == ST_RUN)
            retention_ram[ret_addr_i] <= ret_wdata_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            ret_rdata_o <= 8'h00;
        else
            ret_rdata_o <= retention_ram[ret_addr_i];
    end

    // clock divider select, powers of two up to 128
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            div_sel <= RST_DIV_SEL;
        else if (clk_div_load_i)
            div_sel <= clk_div_sel_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i || state != ST_RUN)
            div_cnt <= 7'h0;
        else
            div_cnt <= div_cnt + 7'h1;
    end

    // processor clock gated by cpu_run_o; divider picks enable stride
    assign sys_clk_en_o = cpu_run_o && ((div_cnt & ((7'h1 << div_sel) - 7'h1)) == 7'h0);
    // timers share the oscillator-derived tick, undivided
    assign timer_tick_o = low_power_oscillator_en_o;

    // peripheral shutdown mask
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            periph_off <= RST_PERIPH_OFF;
        else
            periph_off <= periph_all_off_i ? '1 : periph_off_i;
    end

    assign periph_pwr_o = (state == ST_RUN) ? ~periph_off : '0;

    // crystal runs from tx request until XTAL_START_CYC cycles have passed and trim is done, then off
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i || state != ST_RUN || !xtal_en_i)
        begin
            xtal_on  <= 1'b0;
            xtal_cnt <= 8'h0;
        end
        else if (tx_req_i && !xtal_on)
        begin
            xtal_on  <= 1'b1;
            xtal_cnt <= 8'h0;
        end
        else if (xtal_on)
        begin
            if (xtal_cnt != XTAL_START_CYC[7:0])
                xtal_cnt <= xtal_cnt + 8'h1;
            else if (carrier_trim_done_i)
                xtal_on <= 1'b0;
        end
    end

    assign crystal_oscillator_en_o   = xtal_on;
    assign low_power_oscillator_en_o = (state != ST_STANDBY) && (state != ST_POR);
    assign blocks_pwr_en_o           = low_power_oscillator_en_o;
    assign cpu_run_o                 = (state == ST_RUN);
    assign standby_o                 = (state == ST_STANDBY);
    assign booting_o                 = (state == ST_BOOT);

    chk_por_to_standby: assert property (@(posedge clk_i) disable iff (!rstn_i)
        state == ST_POR |=> state == ST_STANDBY) else $error("no standby after reset");
    chk_standby_power_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
        standby_o |-> !blocks_pwr_en_o && !cpu_run_o) else $error("power on in standby");
    chk_pin_wake: assert property (@(posedge clk_i) disable iff (!rstn_i)
        pin_wake |=> state == ST_OSC_ON) else $error("pin edge did not wake");
    chk_timer_wake: assert property (@(posedge clk_i) disable iff (!rstn_i)
        timer_wake |=> low_power_oscillator_en_o) else $error("timer did not wake");
    chk_boot_start: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(booting_o) |-> bc.busy) else $error("copy not started");
    chk_run_after_copy: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(cpu_run_o) |-> $past(bc.done)) else $error("cpu ran before copy end");
    chk_osc_in_run: assert property (@(posedge clk_i) disable iff (!rstn_i)
        cpu_run_o |-> low_power_oscillator_en_o) else $error("cpu without oscillator");
    chk_periph_all_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
        periph_all_off_i |=> periph_pwr_o == '0) else $error("peripherals still on");
    chk_osc_settle: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(state == ST_OSC_ON) |-> (state == ST_OSC_ON) [*8]) else $error("osc wait short");
    chk_xtal_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !xtal_en_i |=> !crystal_oscillator_en_o) else $error("crystal on while disabled");

endmodule : wake_boot_sequencer

// *** bench/button_otp_model.sv ***
module button_otp_model
    import wake_boot_pkg::*;
(
    // clock and tally clear
    input  wire logic                clk_i,
    input  wire logic                clr_i,
    // button control from the bench
    input  wire logic                press_i,
    input  wire logic [3:0]          pin_sel_i,
    // copy strobes from the sequencer
    input  wire logic                otp_rd_i,
    input  wire logic                ram_we_i,
    // pins and read tally
    output logic [NUM_GPIO-1:0]      gpio_o,
    output logic [15:0]              rd_count_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // pins sit at the pull-up level; a press grounds the one pin pin_sel_i selects, or none if pin_sel_i is past the last pin
    always_comb
    begin
        gpio_o = '1;
        if (press_i)
            gpio_o[pin_sel_i] = 1'b0;
    end

    // every otp read is tallied on its own, so a read without its ram write still shows in the count
    always_ff @(posedge clk_i)
    begin
        if (clr_i)
            rd_count_o <= 16'h0000;
        else if (otp_rd_i)
            rd_count_o <= rd_count_o + 16'h0001;
    end
endmodule : button_otp_model

// *** bench/wake_boot_sequencer_bench.sv ***
module wake_boot_sequencer_bench;
    import wake_boot_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // short fixed phase keeps the run near 8300 cycles per wake
    localparam int unsigned FIX = 4200;
    // per-kilobyte stride must leave room for one byte a cycle over all 4096 bytes
    localparam int unsigned KB  = 1024;
    logic clk_i, rstn_i, sleep_en_i, standby_req_i, clk_div_load_i, periph_all_off_i;
    logic xtal_en_i, tx_req_i, carrier_trim_done_i, ret_we_i, press, clr, otp_rd, ram_we;
    logic lpo_en, xtal_on, blk_en, cpu_run, sclk_en, tick, standby, booting;
    logic [8:0]  gpio;
    logic [31:0] sleep_period_i;
    logic [2:0]  clk_div_sel_i, ret_addr_i;
    logic [7:0]  periph_off_i, ret_wdata_i, ret_rdata, periph_pwr;
    logic [11:0] ram_addr, last_addr;
    logic [15:0] rd_count;
    int          failures, num_checks, i, n, bad;

    wake_boot_sequencer #(.FIXED_CYC(FIX), .KB_CYC(KB)) wake_boot_sequencer_inst (
        .clk_i(clk_i), .rstn_i(rstn_i), .gpio_i(gpio), .sleep_en_i(sleep_en_i),
        .sleep_period_i(sleep_period_i), .standby_req_i(standby_req_i), .clk_div_sel_i(clk_div_sel_i),
        .clk_div_load_i(clk_div_load_i), .periph_off_i(periph_off_i), .periph_all_off_i(periph_all_off_i),
        .xtal_en_i(xtal_en_i), .tx_req_i(tx_req_i), .carrier_trim_done_i(carrier_trim_done_i),
        .ret_we_i(ret_we_i), .ret_addr_i(ret_addr_i), .ret_wdata_i(ret_wdata_i), .ret_rdata_o(ret_rdata),
        .otp_rd_o(otp_rd), .ram_we_o(ram_we), .ram_addr_o(ram_addr), .low_power_oscillator_en_o(lpo_en),
        .crystal_oscillator_en_o(xtal_on), .blocks_pwr_en_o(blk_en), .cpu_run_o(cpu_run),
        .sys_clk_en_o(sclk_en), .timer_tick_o(tick), .periph_pwr_o(periph_pwr), .standby_o(standby),
        .booting_o(booting));

    button_otp_model button_otp_model_inst (
        .clk_i(clk_i), .clr_i(clr), .press_i(press), .pin_sel_i(4'h8), .otp_rd_i(otp_rd),
        .ram_we_i(ram_we), .gpio_o(gpio), .rd_count_o(rd_count));

    // free-running 50 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic step(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask : step

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    // a bounded wait that ran out ends the run at once
    task automatic give_up_if(input logic stuck);
        if (stuck)
        begin
            failures++;
            report_and_stop();
        end
    endtask : give_up_if

    task automatic t_reset;
        step(1);
        check("lpo in reset", 1'b0, lpo_en);
        @(posedge clk_i) rstn_i <= 1'b1;
        step(1);
        check("standby", 1'b1, standby);
        check("cpu", 1'b0, cpu_run);
        check("lpo", 1'b0, lpo_en);
        check("blocks", 1'b0, blk_en);
        step(3);
    endtask : t_reset

    // wake by pin or by timer, then follow the copy to processor release
    task automatic t_boot(input logic by_pin);
        @(posedge clk_i) clr <= 1'b1;
        press <= by_pin;
        @(posedge clk_i) clr <= 1'b0;
        for (i = 0; i < 200 && standby !== 1'b0; i++)
            step(1);
        give_up_if(standby !== 1'b0);
        check("lpo on wake", 1'b1, lpo_en);
        check("cpu on wake", 1'b0, cpu_run);
        @(posedge clk_i) press <= 1'b0;
        n = 0;
        bad = 0;
        for (i = 0; i < 20000 && cpu_run !== 1'b1; i++)
        begin
            step(1);
            if (ram_we === 1'b1)
            begin
                n++;
                last_addr = ram_addr;
            end
            if (cpu_run === 1'b1 && n < 4096)
                bad++;
        end
        give_up_if(cpu_run !== 1'b1);
        check("bytes", 4096, n);
        check("last addr", 12'hFFF, last_addr);
        check("otp reads", 16'h1000, rd_count);
        check("copy time", 1'b1, i >= FIX + 4 * KB && i <= FIX + 4 * KB + OSC_START_CYC);
        check("early run", 0, bad);
        check("booting", 1'b0, booting);
    endtask : t_boot

    task automatic t_run;
        @(posedge clk_i) ret_we_i <= 1'b1;
        ret_addr_i <= 3'h7;
        ret_wdata_i <= 8'hA5;
        periph_off_i <= 8'h0F;
        press <= 1'b1;
        @(posedge clk_i) ret_we_i <= 1'b0;
        step(2);
        check("ret read", 8'hA5, ret_rdata);
        check("periph mask", 8'hF0, periph_pwr);
        check("timer tick", 1'b1, tick);
        @(posedge clk_i) periph_all_off_i <= 1'b1;
        press <= 1'b0;
        step(2);
        check("all off", 8'h00, periph_pwr);
        check("no reboot", 1'b0, booting);
        @(posedge clk_i) periph_all_off_i <= 1'b0;
        clk_div_sel_i <= 3'h2;
        clk_div_load_i <= 1'b1;
        @(posedge clk_i) clk_div_load_i <= 1'b0;
        step(4);
        n = 0;
        for (i = 0; i < 16; i++)
        begin
            step(1);
            n += int'(sclk_en === 1'b1);
        end
        check("div pulses", 4, n);
        @(posedge clk_i) xtal_en_i <= 1'b1;
        tx_req_i <= 1'b1;
        @(posedge clk_i) tx_req_i <= 1'b0;
        carrier_trim_done_i <= 1'b1;
        for (i = 0; i < 4 && xtal_on !== 1'b1; i++)
            step(1);
        check("xtal on", 1'b1, xtal_on);
        for (n = 0; n < 200 && xtal_on === 1'b1; n++)
            step(1);
        check("xtal settle", 1'b1, n >= 64 && n < 200);
        @(posedge clk_i) carrier_trim_done_i <= 1'b0;
    endtask : t_run

    // back to standby, then the sleep timer alone must wake and copy again
    task automatic t_standby;
        @(posedge clk_i) standby_req_i <= 1'b1;
        @(posedge clk_i) standby_req_i <= 1'b0;
        step(1);
        check("standby again", 1'b1, standby);
        check("lpo off", 1'b0, lpo_en);
        check("periph off", 8'h00, periph_pwr);
        @(posedge clk_i) sleep_en_i <= 1'b1;
        sleep_period_i <= 32'h0000_0032;
        t_boot(1'b0);
        @(posedge clk_i) sleep_en_i <= 1'b0;
        step(2);
        check("ret kept", 8'hA5, ret_rdata);
    endtask : t_standby

    initial
    begin
        {rstn_i, sleep_en_i, standby_req_i, clk_div_load_i, periph_all_off_i} = '0;
        {xtal_en_i, tx_req_i, carrier_trim_done_i, ret_we_i, press, clr} = '0;
        {sleep_period_i, clk_div_sel_i, ret_addr_i, periph_off_i, ret_wdata_i} = '0;
        failures = 0;
        num_checks = 0;
        t_reset();
        t_boot(1'b1);
        t_run();
        t_standby();
        report_and_stop();
    end
endmodule : wake_boot_sequencer_bench
